// ### src/i2chc_pkg.sv
// Shared constants and state types of the I2C host/client port.
package i2chc_pkg;

	// ---------------------------------------------------------------
	// Register indices on the plain register port
	// ---------------------------------------------------------------
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	localparam logic [2:0] REG_CTRL1 = 3'h0;
	localparam logic [2:0] REG_CTRL2 = 3'h1;
	localparam logic [2:0] REG_STATUS = 3'h2;
	localparam logic [2:0] REG_BUF = 3'h3;
	localparam logic [2:0] REG_BAUD = 3'h4;
	localparam logic [2:0] REG_OWNADR = 3'h5;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int C1_EN = 4;
	localparam int C1_CKP = 5;
	localparam int C1_ADDRESS_HOLD_ENABLE = 6;
	localparam int C1_START_INTERRUPT_ENABLE = 7;
	localparam int C1_SWSCL = 8;
	localparam int C1_SWSDA = 9;
	localparam int C2_SEN = 0;
	localparam int C2_REPEAT_START_ENABLE = 1;
	localparam int C2_ACK_DATA_BIT = 5;
	localparam int ST_WRITE_COLLISION_FLAG = 6;
	localparam int ST_BCOL = 7;
	localparam int ST_IRQ = 8;

	// ---------------------------------------------------------------
	// Modes, reset values and counts
	// ---------------------------------------------------------------
	localparam logic [3:0] MODE_CLIENT = 4'h6;
	localparam logic [3:0] MODE_HOST = 4'h8;
	localparam logic [3:0] MODE_FWHOST = 4'hb;
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [7:0] BAUD_RST = 8'h04;
	localparam logic [6:0] OWNADR_RST = 7'h00;
	localparam logic [3:0] BITS_BYTE = 4'h8;

	typedef enum logic [3:0] {
		H_IDLE = 4'b0000,
		H_ST1 = 4'b0001,
		H_ST2 = 4'b0010,
		H_RS1 = 4'b0011,
		H_RS2 = 4'b0100,
		H_RS3 = 4'b0101,
		H_RS4 = 4'b0110,
		H_RS5 = 4'b0111,
		H_TXL = 4'b1000,
		H_TXR = 4'b1001,
		H_TXH = 4'b1010
	} i2chc_host_e;

	typedef enum logic [2:0] {
		C_IDLE = 3'b000,
		C_ADDR = 3'b001,
		C_ACK = 3'b010,
		C_TX = 3'b011,
		C_MACK = 3'b100
	} i2chc_client_e;

endpackage : i2chc_pkg

// ### src/i2chc_top.sv
// I2C port: client transmit with address hold, host Start/Restart/byte transmit.
//
// Contract
// - Address hold: after eighth fall of matching address clear clock release, set flag.
// - During address hold, acknowledge slot carries ack data bit once clock released.
// - After acknowledging a read address, clear clock release and set flag.
// - Transmit buffer load refused before address acknowledge ends; load sets buffer full.
// - Copy host acknowledge of each transmitted byte into acknowledge status.
// - Host mode with port enabled drives SDA and SCL low only when needed.
// - Start/stop flags clear on reset or disable; Start only after stop or idle.
// - Firmware host mode: only Start/Stop detection active, software drives lines.
// - Host mode flag set on start, stop, byte/ack done, repeated start.
// - Host never queues: buffer write while busy is dropped, sets write collision.
// - Start detection suspended while generating Start; flag set when enable clears.
// - Writes to low five bits of second control ignored during Start.
// - Released SCL: baud counter waits for SCL high, then reloads and counts.
// - Host clocks eight data bits plus ninth acknowledge; first byte address plus R/W.
// - Start: lines high reload baud counter; still high at timeout drive SDA low.
// - After SDA low, count once more; at timeout clear enable, halt, keep SDA.
// - Lines low at Start, or SCL low early: bus collision, abort, idle.
// - Restart only from idle: SCL low, reload once low, release SDA one period.
// - Timeout with SDA high releases SCL; high period, SDA low period, SCL low.
// - Restart end clears enable, no reload, SDA held low, flag at timeout.
// - Acknowledge status updates on ninth rising SCL; other status on falls.
// - Restart collision if SDA low at SCL rise or SCL falls early.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module i2chc_top #(
	parameter int BAUD_W = 8
) (
	input wire logic CLK, // System clock, 100 MHz
	input wire logic SYS_RST, // Asynchronous reset, active high
	input wire logic [i2chc_pkg::ADDR_W-1:0] ADDR, // Register index
	input wire logic [i2chc_pkg::DATA_W-1:0] WDATA, // Write data
	input wire logic WR, // Write strobe
	input wire logic RD, // Read strobe
	output logic [i2chc_pkg::DATA_W-1:0] RDATA, // Read data, cycle after RD
	input wire logic SCL_I, // SCL level on the bus
	output logic SCL_O, // SCL output level, always low
	output logic SCL_OE, // High while SCL is pulled low
	input wire logic SDA_I, // SDA level on the bus
	output logic SDA_O, // SDA output level, always low
	output logic SDA_OE // High while SDA is pulled low
);
	import i2chc_pkg::*;

	function automatic logic msb_bit(input logic [7:0] b, input logic [3:0] n);
		return b[3'h7 - n[2:0]];
	endfunction : msb_bit

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [3:0] mode_q;
	logic en_q, ckp_q, address_hold_enable_q, start_interrupt_enable_q, sw_scl_q, sw_sda_q;
	logic sen_q, repeat_start_enable_q, ack_data_bit_q;
	logic start_det_q, stop_det_q, bf_q, ack_status_bit_q, rw_q, ack_time_flag_q;
	logic write_collision_flag_q, bcol_q, irq_q, bus_busy_q;
	logic [7:0] buf_q, csh_q;
	logic [BAUD_W-1:0] baud_q, brg_q;
	logic [6:0] own_q;
	logic brg_run_q;
	i2chc_host_e hst_q;
	i2chc_client_e cst_q;
	logic [3:0] hcnt_q, ccnt_q;
	logic hold_scl_q, hold_sda_q;
	logic scl_prev_q, sda_prev_q;

	// ---------------------------------------------------------------
	// Decode and events
	// ---------------------------------------------------------------
	logic host_on, fw_on, client_on, brg_to, scl_rise, scl_fall;
	logic det_on, start_seen, stop_seen;
	logic wr_c1, wr_c2, wr_st, wr_buf, rd_buf, buf_ok, buf_acc;
	logic h_coll, h_st_set, h_st_done, h_rs_done, h_byte_done, h_ack_smp, h_bf_clr;
	logic c_addr_done, c_match, c_ack_end, c_ack_val, c_tx_end, c_mack_rise, c_mack_end;
	logic host_scl_low, host_sda_low, client_scl_low, client_sda_low;
	logic c2_locked;

	assign host_on = en_q && (mode_q == MODE_HOST);
	assign fw_on = en_q && (mode_q == MODE_FWHOST);
	assign client_on = en_q && (mode_q == MODE_CLIENT);
	assign brg_to = brg_run_q && (brg_q == '0);
	assign scl_rise = SCL_I && !scl_prev_q;
	assign scl_fall = !SCL_I && scl_prev_q;

	// Own Start generation must not raise the detector
	assign det_on = en_q && !(host_on && (hst_q == H_ST1 || hst_q == H_ST2));
	assign start_seen = det_on && SCL_I && scl_prev_q && sda_prev_q && !SDA_I;
	assign stop_seen = det_on && SCL_I && scl_prev_q && !sda_prev_q && SDA_I;

	assign wr_c1 = WR && (ADDR == REG_CTRL1);
	assign wr_c2 = WR && (ADDR == REG_CTRL2);
	assign wr_st = WR && (ADDR == REG_STATUS);
	assign wr_buf = WR && (ADDR == REG_BUF);
	assign rd_buf = RD && (ADDR == REG_BUF);

	assign buf_ok = host_on ? (hst_q == H_IDLE && !sen_q && !repeat_start_enable_q) :
		client_on ? (cst_q == C_TX && ccnt_q == 4'h0) :
		!fw_on;
	assign buf_acc = wr_buf && buf_ok;
	assign c2_locked = sen_q || hst_q == H_ST1 || hst_q == H_ST2;

	assign h_coll = host_on && ((hst_q == H_IDLE && sen_q && !(SDA_I && SCL_I)) ||
		(hst_q == H_ST1 && (!SCL_I || (brg_to && !SDA_I))) ||
		(hst_q == H_RS3 && SCL_I && !SDA_I) ||
		(hst_q == H_RS4 && !SCL_I));
	assign h_st_set = host_on && hst_q == H_ST1 && brg_to && SDA_I && SCL_I;
	assign h_st_done = host_on && hst_q == H_ST2 && brg_to;
	assign h_rs_done = host_on && hst_q == H_RS5 && brg_to;
	assign h_byte_done = host_on && hst_q == H_TXH && brg_to && hcnt_q == BITS_BYTE;
	assign h_ack_smp = host_on && hst_q == H_TXR && SCL_I && hcnt_q == BITS_BYTE;
	assign h_bf_clr = host_on && hst_q == H_TXH && brg_to && hcnt_q == 4'h7;

	assign c_match = csh_q[7:1] == own_q;
	assign c_addr_done = client_on && cst_q == C_ADDR && scl_fall && ccnt_q == BITS_BYTE;
	assign c_ack_val = address_hold_enable_q ? ack_data_bit_q : 1'b0;
	assign c_ack_end = client_on && cst_q == C_ACK && scl_fall;
	assign c_tx_end = client_on && cst_q == C_TX && scl_fall && ccnt_q == 4'h7;
	assign c_mack_rise = client_on && cst_q == C_MACK && scl_rise;
	assign c_mack_end = client_on && cst_q == C_MACK && scl_fall;

	// ---------------------------------------------------------------
	// Line drive
	// ---------------------------------------------------------------
	always_comb begin
		host_scl_low = 1'b0;
		host_sda_low = 1'b0;
		unique case (hst_q)
			H_IDLE: begin
				host_scl_low = hold_scl_q;
				host_sda_low = hold_sda_q;
			end
			H_ST1: host_sda_low = 1'b0;
			H_ST2: host_sda_low = 1'b1;
			H_RS1: begin
				host_scl_low = 1'b1;
				host_sda_low = hold_sda_q;
			end
			H_RS2: host_scl_low = 1'b1;
			H_RS3: host_sda_low = 1'b0;
			H_RS4: host_sda_low = 1'b0;
			H_RS5: host_sda_low = 1'b1;
			H_TXL: begin
				host_scl_low = 1'b1;
				host_sda_low = hcnt_q < BITS_BYTE && !msb_bit(buf_q, hcnt_q);
			end
			H_TXR, H_TXH: host_sda_low = hcnt_q < BITS_BYTE && !msb_bit(buf_q, hcnt_q);
		endcase
	end

	// Client stretches in acknowledge, transmit and host-acknowledge states while software holds the clock release low
	assign client_scl_low = cst_q != C_IDLE && cst_q != C_ADDR && !ckp_q;
	assign client_sda_low = (cst_q == C_ACK && !c_ack_val) ||
		(cst_q == C_TX && !msb_bit(buf_q, ccnt_q));

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			SCL_OE <= 1'b0;
			SDA_OE <= 1'b0;
			SCL_O <= 1'b0;
			SDA_O <= 1'b0;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			SCL_OE <= host_on ? host_scl_low : fw_on ? sw_scl_q :
				client_on && client_scl_low;
			SDA_OE <= host_on ? host_sda_low : fw_on ? sw_sda_q :
				client_on && client_sda_low;
			SCL_O <= 1'b0;
			SDA_O <= 1'b0;
			scl_prev_q <= SCL_I;
			sda_prev_q <= SDA_I;
		end
	end

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			mode_q <= MODE_RST;
			en_q <= 1'b0;
			ckp_q <= 1'b1;
			address_hold_enable_q <= 1'b0;
			start_interrupt_enable_q <= 1'b0;
			sw_scl_q <= 1'b0;
			sw_sda_q <= 1'b0;
			ack_data_bit_q <= 1'b0;
			baud_q <= BAUD_RST[BAUD_W-1:0];
			own_q <= OWNADR_RST;
		end else begin
			if (wr_c1) begin
				mode_q <= WDATA[3:0];
				en_q <= WDATA[C1_EN];
				address_hold_enable_q <= WDATA[C1_ADDRESS_HOLD_ENABLE];
				start_interrupt_enable_q <= WDATA[C1_START_INTERRUPT_ENABLE];
				sw_scl_q <= WDATA[C1_SWSCL];
				sw_sda_q <= WDATA[C1_SWSDA];
			end
			// Hardware stretch wins over a software release in the same cycle
			if ((c_addr_done && c_match && address_hold_enable_q) ||
					(c_ack_end && rw_q && !c_ack_val) ||
					(c_mack_end && !ack_status_bit_q)) begin
				ckp_q <= 1'b0;
			end else if (wr_c1) begin
				ckp_q <= WDATA[C1_CKP];
			end
			if (wr_c2) begin
				ack_data_bit_q <= WDATA[C2_ACK_DATA_BIT];
			end
			if (WR && ADDR == REG_BAUD) begin
				baud_q <= WDATA[BAUD_W-1:0];
			end
			if (WR && ADDR == REG_OWNADR) begin
				own_q <= WDATA[6:0];
			end
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sen_q <= 1'b0;
			repeat_start_enable_q <= 1'b0;
		end else begin
			if (!host_on || h_coll) begin
				sen_q <= 1'b0;
				repeat_start_enable_q <= 1'b0;
			end else begin
				if (h_st_done) begin
					sen_q <= 1'b0;
				end else if (wr_c2 && !c2_locked && hst_q == H_IDLE && WDATA[C2_SEN] &&
						(stop_det_q || !bus_busy_q)) begin
					sen_q <= 1'b1;
				end
				if (h_rs_done) begin
					repeat_start_enable_q <= 1'b0;
				end else if (wr_c2 && !c2_locked && hst_q == H_IDLE && WDATA[C2_REPEAT_START_ENABLE]) begin
					repeat_start_enable_q <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Status flags
	// ---------------------------------------------------------------
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			start_det_q <= 1'b0;
			stop_det_q <= 1'b0;
			bus_busy_q <= 1'b0;
		end else if (!en_q) begin
			start_det_q <= 1'b0;
			stop_det_q <= 1'b0;
			bus_busy_q <= 1'b0;
		end else if (start_seen || h_st_set) begin
			start_det_q <= 1'b1;
			stop_det_q <= 1'b0;
			bus_busy_q <= 1'b1;
		end else if (stop_seen) begin
			start_det_q <= 1'b0;
			stop_det_q <= 1'b1;
			bus_busy_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			irq_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			bcol_q <= 1'b0;
		end else begin
			// Write-one-to-clear; a new event in the same cycle keeps the bit set
			if ((host_on && (start_seen || stop_seen || h_st_done ||
					h_rs_done || h_byte_done)) ||
					(client_on && start_seen && start_interrupt_enable_q) ||
					(c_addr_done && c_match && address_hold_enable_q) ||
					(c_ack_end && rw_q && !c_ack_val) ||
					c_mack_end) begin
				irq_q <= 1'b1;
			end else if (wr_st && WDATA[ST_IRQ]) begin
				irq_q <= 1'b0;
			end
			if (wr_buf && !buf_ok) begin
				write_collision_flag_q <= 1'b1;
			end else if (wr_st && WDATA[ST_WRITE_COLLISION_FLAG]) begin
				write_collision_flag_q <= 1'b0;
			end
			if (h_coll) begin
				bcol_q <= 1'b1;
			end else if (wr_st && WDATA[ST_BCOL]) begin
				bcol_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			bf_q <= 1'b0;
			buf_q <= 8'h00;
			ack_status_bit_q <= 1'b0;
			rw_q <= 1'b0;
			ack_time_flag_q <= 1'b0;
		end else begin
			if (buf_acc) begin
				bf_q <= 1'b1;
				buf_q <= WDATA[7:0];
			end else if (c_addr_done && c_match) begin
				bf_q <= 1'b1;
				buf_q <= csh_q;
			end else if (h_bf_clr || c_tx_end) begin
				bf_q <= 1'b0;
			end else if (rd_buf && cst_q != C_TX && cst_q != C_MACK && hst_q == H_IDLE) begin
				bf_q <= 1'b0;
			end
			if (h_ack_smp || c_mack_rise) begin
				ack_status_bit_q <= SDA_I;
			end
			if (c_addr_done && c_match) begin
				rw_q <= csh_q[0];
				ack_time_flag_q <= 1'b1;
			end else if (c_ack_end) begin
				ack_time_flag_q <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Client sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			cst_q <= C_IDLE;
			ccnt_q <= 4'h0;
			csh_q <= 8'h00;
		end else if (!client_on || stop_seen) begin
			cst_q <= C_IDLE;
			ccnt_q <= 4'h0;
		end else if (start_seen) begin
			cst_q <= C_ADDR;
			ccnt_q <= 4'h0;
		end else begin
			unique case (cst_q)
				C_IDLE: ccnt_q <= 4'h0;
				C_ADDR: begin
					if (scl_rise && ccnt_q < BITS_BYTE) begin
						csh_q <= {csh_q[6:0], SDA_I};
						ccnt_q <= ccnt_q + 4'h1;
					end else if (c_addr_done) begin
						cst_q <= c_match ? C_ACK : C_IDLE;
					end
				end
				C_ACK: begin
					if (c_ack_end) begin
						ccnt_q <= 4'h0;
						// Receive direction is not served here; a NACK ends it
						cst_q <= (rw_q && !c_ack_val) ? C_TX : C_IDLE;
					end
				end
				C_TX: begin
					if (c_tx_end) begin
						cst_q <= C_MACK;
					end else if (scl_fall) begin
						ccnt_q <= ccnt_q + 4'h1;
					end
				end
				C_MACK: begin
					if (c_mack_end) begin
						ccnt_q <= 4'h0;
						cst_q <= ack_status_bit_q ? C_IDLE : C_TX;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Host sequencer and baud counter
	// ---------------------------------------------------------------
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			hst_q <= H_IDLE;
			hcnt_q <= 4'h0;
			brg_q <= '0;
			brg_run_q <= 1'b0;
			hold_scl_q <= 1'b0;
			hold_sda_q <= 1'b0;
		end else if (!host_on || h_coll) begin
			hst_q <= H_IDLE;
			brg_run_q <= 1'b0;
			hold_scl_q <= 1'b0;
			hold_sda_q <= 1'b0;
		end else begin
			if (brg_run_q && brg_q != '0) begin
				brg_q <= brg_q - 1'b1;
			end
			unique case (hst_q)
				H_IDLE: begin
					if (sen_q) begin
						brg_q <= baud_q;
						brg_run_q <= 1'b1;
						hst_q <= H_ST1;
					end else if (repeat_start_enable_q) begin
						hst_q <= H_RS1;
					end else if (buf_acc) begin
						brg_q <= baud_q;
						brg_run_q <= 1'b1;
						hcnt_q <= 4'h0;
						hst_q <= H_TXL;
					end
				end
				H_ST1: begin
					if (h_st_set) begin
						brg_q <= baud_q;
						hst_q <= H_ST2;
					end
				end
				H_ST2: begin
					if (h_st_done) begin
						brg_run_q <= 1'b0;
						hold_sda_q <= 1'b1;
						hold_scl_q <= 1'b0;
						hst_q <= H_IDLE;
					end
				end
				H_RS1: begin
					if (!SCL_I) begin
						brg_q <= baud_q;
						brg_run_q <= 1'b1;
						hst_q <= H_RS2;
					end
				end
				H_RS2: begin
					if (brg_to) begin
						brg_run_q <= 1'b0;
					end
					// Waits past timeout while another party still holds SDA
					if ((brg_to || !brg_run_q) && SDA_I) begin
						brg_run_q <= 1'b0;
						hst_q <= H_RS3;
					end
				end
				H_RS3: begin
					if (SCL_I) begin
						brg_q <= baud_q;
						brg_run_q <= 1'b1;
						hst_q <= H_RS4;
					end
				end
				H_RS4: begin
					if (brg_to) begin
						brg_q <= baud_q;
						hst_q <= H_RS5;
					end
				end
				H_RS5: begin
					if (h_rs_done) begin
						brg_run_q <= 1'b0;
						hold_sda_q <= 1'b1;
						hold_scl_q <= 1'b1;
						hst_q <= H_IDLE;
					end
				end
				H_TXL: begin
					if (brg_to) begin
						brg_run_q <= 1'b0;
						hst_q <= H_TXR;
					end
				end
				H_TXR: begin
					if (SCL_I) begin
						brg_q <= baud_q;
						brg_run_q <= 1'b1;
						hst_q <= H_TXH;
					end
				end
				H_TXH: begin
					if (h_byte_done) begin
						brg_run_q <= 1'b0;
						hold_scl_q <= 1'b1;
						hold_sda_q <= 1'b0;
						hst_q <= H_IDLE;
					end else if (brg_to) begin
						hcnt_q <= hcnt_q + 4'h1;
						brg_q <= baud_q;
						hst_q <= H_TXL;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RDATA <= 16'h0000;
		end else if (RD) begin
			unique case (ADDR)
				REG_CTRL1: RDATA <= {6'h00, sw_sda_q, sw_scl_q, start_interrupt_enable_q, address_hold_enable_q, ckp_q, en_q, mode_q};
				REG_CTRL2: RDATA <= {10'h000, ack_data_bit_q, 3'h0, repeat_start_enable_q, sen_q};
				REG_STATUS: RDATA <= {7'h00, irq_q, bcol_q, write_collision_flag_q, ack_time_flag_q, rw_q, ack_status_bit_q,
					bf_q, stop_det_q, start_det_q};
				REG_BUF: RDATA <= {8'h00, buf_q};
				REG_BAUD: RDATA <= {{(16-BAUD_W){1'b0}}, baud_q};
				REG_OWNADR: RDATA <= {9'h000, own_q};
				default: RDATA <= 16'h0000;
			endcase
		end
	end

endmodule : i2chc_top

`default_nettype wire

// ### testbench/i2chc_assertions.sv
// Port-level assertions of the I2C host/client port.
`timescale 1ns/1ps
`default_nettype none
module i2chc_chk
	import i2chc_pkg::*;
#(
	parameter int BAUD_W = 8
) (
	input wire logic CLK, // Clock
	input wire logic SYS_RST, // Reset
	input wire logic [i2chc_pkg::ADDR_W-1:0] ADDR, // Index
	input wire logic [i2chc_pkg::DATA_W-1:0] WDATA, // Write data
	input wire logic WR, // Write strobe
	input wire logic RD, // Read strobe
	input wire logic [i2chc_pkg::DATA_W-1:0] RDATA, // Read data
	input wire logic SCL_I, // SCL level
	input wire logic SCL_O, // SCL out
	input wire logic SCL_OE, // SCL pull
	input wire logic SDA_I, // SDA level
	input wire logic SDA_O, // SDA out
	input wire logic SDA_OE // SDA pull
);
	// ----
	// Mode as last written
	// ----
	logic [3:0] mode_q;
	logic en_q;
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			mode_q <= MODE_RST;
			en_q <= 1'b0;
		end else if (WR && ADDR == REG_CTRL1) begin
			mode_q <= WDATA[3:0];
			en_q <= WDATA[C1_EN];
		end
	end
	wire logic host = en_q && mode_q == MODE_HOST;
	wire logic cli = en_q && mode_q == MODE_CLIENT;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	AST_PIN_LOW: assert property (!SCL_O && !SDA_O)
		else $error("pin level not low");
	AST_OFF_QUIET: assert property (!en_q && !$past(en_q) && !$past(en_q, 2)
		|-> !SCL_OE && !SDA_OE) else $error("pins pulled while disabled");
	AST_FW_FOLLOW: assert property (WR && ADDR == REG_CTRL1 && WDATA[3:0] == MODE_FWHOST
		&& WDATA[C1_EN] |-> ##2 SCL_OE == $past(WDATA[C1_SWSCL], 2)
		&& SDA_OE == $past(WDATA[C1_SWSDA], 2)) else $error("software pins not followed");
	AST_HIGH_MIN: assert property (host && $rose(SCL_OE)
		|-> $past(SCL_I) && $past(SCL_I, 2)) else $error("SCL high period short");
	AST_STRETCH: assert property (cli && $rose(SCL_OE) |-> !$past(SCL_I))
		else $error("client pulled SCL while high");
	AST_CLI_SDA: assert property (cli && $changed(SDA_OE) |-> !SCL_I && !$past(SCL_I))
		else $error("client SDA moved while SCL high");
	AST_HOST_REL: assert property (host && $fell(SDA_OE) |-> SCL_OE)
		else $error("host released SDA with SCL free");
	AST_START_SDA: assert property (host && $rose(SDA_OE) && !SCL_OE
		|-> $past(SCL_I) && $past(SDA_I)) else $error("SDA pulled with lines low");
	cover property (host && $rose(SCL_OE));
	cover property (cli && $rose(SCL_OE));
	cover property (host && $rose(SDA_OE) && !SCL_OE);
endmodule : i2chc_chk
`default_nettype wire

// ### testbench/i2chc_peer.sv
// Far-side I2C party, host or client, open-drain with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module i2chc_peer (
	input wire logic CLK, // Clock
	input wire logic SCL, // Bus SCL
	input wire logic SDA, // Bus SDA
	output logic scl_pull, // Pulls SCL low
	output logic sda_pull // Pulls SDA low
);
	// ----
	// Bit and byte sequences
	// ----
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	// Bounded so a stuck line cannot hang the run
	task w(input logic v);
		int n;
		n = 0;
		while (SCL !== v && n < 3000) begin
			@(posedge CLK);
			n++;
		end
	endtask : w
	task hstart;
		sda_pull <= 1'b1;
		repeat (8) @(posedge CLK);
		scl_pull <= 1'b1;
		@(posedge CLK);
	endtask : hstart
	// Host bit honours clock stretching by waiting for SCL high
	task hbit(input logic b, output logic r);
		sda_pull <= !b;
		repeat (8) @(posedge CLK);
		scl_pull <= 1'b0;
		@(posedge CLK);
		w(1'b1);
		repeat (8) @(posedge CLK);
		r = SDA;
		scl_pull <= 1'b1;
		@(posedge CLK);
	endtask : hbit
	task hbyte(input logic [7:0] d, input logic ack, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) hbit(i > 0 ? d[i-1] : ack, r[i]);
	endtask : hbyte
	// Client stretches SCL st cycles after the eighth fall, its answer already on SDA
	task cbyte(input logic nack, input int st, output logic [7:0] d);
		w(1'b0);
		for (int i = 7; i >= 0; i--) begin
			w(1'b1);
			d[i] = SDA;
			w(1'b0);
		end
		scl_pull <= 1'b1;
		sda_pull <= !nack;
		repeat (st) @(posedge CLK);
		scl_pull <= 1'b0;
		w(1'b1);
		w(1'b0);
		sda_pull <= 1'b0;
	endtask : cbyte
endmodule : i2chc_peer
`default_nettype wire

// ### testbench/i2chc_top_bench.sv
// Self-checking bench of the I2C host/client port.
`timescale 1ns/1ps
`default_nettype none
module i2chc_top_bench;
	import i2chc_pkg::*;
	logic CLK, SYS_RST, WR, RD, SCL_O, SCL_OE, SDA_O, SDA_OE, scl_pull, sda_pull;
	logic [ADDR_W-1:0] ADDR;
	logic [DATA_W-1:0] WDATA, RDATA;
	logic [8:0] hr;
	logic [7:0] cd;
	int n_mismatch = 0, num_checks = 0, cyc = 0;
	wire logic scl = !(SCL_OE | scl_pull);
	wire logic sda = !(SDA_OE | sda_pull);
	i2chc_top i2chc_top_inst (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .SCL_I(scl), .SCL_O(SCL_O), .SCL_OE(SCL_OE),
		.SDA_I(sda), .SDA_O(SDA_O), .SDA_OE(SDA_OE));
	i2chc_peer i2chc_peer_inst (.CLK(CLK), .SCL(scl), .SDA(sda), .scl_pull(scl_pull),
		.sda_pull(sda_pull));
	// ----
	// Clock, timeout, bus tasks
	// ----
	initial begin
		CLK = 1'b0;
		forever #5 CLK = !CLK;
	end
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// A gap cycle after each strobe keeps one assignment per step
	task wr(input logic [2:0] a, input logic [15:0] d);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
		@(posedge CLK);
	endtask : wr
	task rd(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		@(posedge CLK);
		chk("RDATA", e, RDATA & m);
	endtask : rd
	// Polls the flag; read data are taken in the cycle after the strobe only
	task wirq;
		logic got;
		got = 1'b0;
		for (int i = 0; i < 400 && got !== 1'b1; i++) begin
			ADDR <= REG_STATUS;
			RD <= 1'b1;
			@(posedge CLK);
			RD <= 1'b0;
			@(posedge CLK);
			got = RDATA[ST_IRQ];
			if (got !== 1'b1) repeat (3) @(posedge CLK);
		end
		chk("IRQ", 16'h0001, {15'h0, got});
	endtask : wirq
	task rst;
		SYS_RST <= 1'b1;
		repeat (6) @(posedge CLK);
		SYS_RST <= 1'b0;
		@(posedge CLK);
	endtask : rst
	initial begin
		SYS_RST = 1'b1;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = '0;
		WDATA = '0;
		rst();
		rd(REG_CTRL1, 16'hffff, 16'h0020);
		rd(REG_STATUS, 16'hffff, 16'h0000);
		rd(REG_BAUD, 16'h00ff, 16'h0004);
		rd(3'h6, 16'hffff, 16'h0000);
		wr(REG_CTRL1, 16'h031b);
		repeat (3) @(posedge CLK);
		chk("OE", 16'h0003, {14'h0, SCL_OE, SDA_OE});
		rst();
		wr(REG_CTRL1, 16'h0018);
		wr(REG_CTRL2, 16'h0001);
		wr(REG_CTRL2, 16'h0002);
		wr(REG_BUF, 16'h00a5);
		wirq();
		rd(REG_STATUS, 16'h01ff, 16'h0141);
		rd(REG_CTRL2, 16'h0003, 16'h0000);
		wr(REG_STATUS, 16'h01c0);
		for (int k = 0; k < 2; k++) begin
			fork
				i2chc_peer_inst.cbyte(k[0], 40, cd);
				begin
					wr(REG_BUF, 16'h00a5 ^ k[15:0]);
					wr(REG_BUF, 16'h0000);
					wirq();
				end
			join
			chk("BYTE", 16'h00a5 ^ k[15:0], {8'h00, cd});
			rd(REG_STATUS, 16'h01cd, 16'h0141 | {k[12:0], 3'h0});
			wr(REG_STATUS, 16'h01c0);
		end
		wr(REG_CTRL2, 16'h0002);
		wirq();
		rd(REG_STATUS, 16'h01c1, 16'h0101);
		rd(REG_CTRL2, 16'h0002, 16'h0000);
		rst();
		wr(REG_CTRL1, 16'h0018);
		// A held SCL raises no Start on the detector, so the request is taken and collides
		i2chc_peer_inst.scl_pull <= 1'b1;
		wr(REG_CTRL2, 16'h0001);
		repeat (20) @(posedge CLK);
		rd(REG_STATUS, 16'h00c1, 16'h0080);
		i2chc_peer_inst.scl_pull <= 1'b0;
		rst();
		wr(REG_OWNADR, 16'h002a);
		wr(REG_CTRL1, 16'h0076);
		fork
			begin
				i2chc_peer_inst.hstart();
				i2chc_peer_inst.hbyte(8'h55, 1'b1, hr);
				chk("ACK", 16'h0000, {15'h0, hr[0]});
				i2chc_peer_inst.hbyte(8'hff, 1'b1, hr);
				chk("TX", 16'h003c, {8'h00, hr[8:1]});
			end
			begin
				wirq();
				rd(REG_STATUS, 16'h01ff, 16'h0135);
				rd(REG_CTRL1, 16'h0020, 16'h0000);
				rd(REG_BUF, 16'h00ff, 16'h0055);
				wr(REG_BUF, 16'h003c);
				wr(REG_STATUS, 16'h0100);
				wr(REG_CTRL1, 16'h0076);
				wirq();
				rd(REG_STATUS, 16'h01c4, 16'h0140);
				rd(REG_CTRL1, 16'h0020, 16'h0000);
				wr(REG_STATUS, 16'h01c0);
				wr(REG_BUF, 16'h003c);
				rd(REG_STATUS, 16'h0004, 16'h0004);
				wr(REG_CTRL1, 16'h0076);
				wirq();
				rd(REG_STATUS, 16'h0008, 16'h0008);
			end
		join
		chk("SCL_OE", 16'h0000, {15'h0, SCL_OE});
		end_sim();
	end
endmodule : i2chc_top_bench
bind i2chc_top i2chc_chk #(.BAUD_W(BAUD_W)) i2chc_chk_inst (.CLK(CLK), .SYS_RST(SYS_RST),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SCL_I(SCL_I),
	.SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE));
`default_nettype wire
